// file: rtl/rfb_pkg.sv
// Shared constants, carrier types and helpers for the registered fanout buffer
package rfb_pkg;

  // ****************************************
  // Widths and depths
  // ****************************************
  localparam int unsigned RFB_WIDTH      = 13;  // Register stage width
  localparam int unsigned RFB_COPIES     = 2;   // Output copies per bit
  localparam int unsigned RFB_FIFO_DEPTH = 16;  // Words buffered between capture and outputs

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [RFB_WIDTH-1:0] RFB_DATA_RST = 13'h0000;  // Registers and outputs low
  localparam logic                 RFB_PIN_RST  = 1'h0;      // Receiver view while disabled

  // ****************************************
  // Carrier types
  // ****************************************
  // Everything sampled from the pins in one cycle
  typedef struct packed {
    logic                 clk_true;
    logic                 clk_comp;
    logic [RFB_WIDTH-1:0] data;
  } rfb_pins_t;

  // Both output copies of the register stage
  typedef struct packed {
    logic [RFB_WIDTH-1:0] copy_a;
    logic [RFB_WIDTH-1:0] copy_b;
  } rfb_outs_t;

  // ****************************************
  // Helpers
  // ****************************************
  // True clock rising while the complementary clock falls
  function automatic logic rfb_crossing(input rfb_pins_t prev, input rfb_pins_t cur);
    rfb_crossing = !prev.clk_true && cur.clk_true && prev.clk_comp && !cur.clk_comp;
  endfunction

endpackage

// file: rtl/rfb_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rfb_fifo
  import rfb_pkg::*;
#(
  parameter int unsigned WIDTH = RFB_WIDTH,
  parameter int unsigned DEPTH = RFB_FIFO_DEPTH
) (
  input  wire logic             clk,        // System clock
  input  wire logic             rst_n,      // Synchronous reset, active low
  input  wire logic             in_valid,   // Write request
  output logic                  in_ready,   // Room for a word
  input  wire logic [WIDTH-1:0] in_data,    // Word to store
  output logic                  out_valid,  // A word is waiting
  input  wire logic             out_ready,  // Consumer takes the word
  output logic      [WIDTH-1:0] out_data    // Oldest word
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ZERO = '0;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } rfb_fifo_st_t;

  rfb_fifo_st_t st_q;
  rfb_fifo_st_t st_d;
  logic         push;
  logic         pop;

  // ****************************************
  // Handshake
  // ****************************************
  // Honest flags straight from the occupancy count
  assign in_ready  = (st_q.count != CNT_FULL);
  assign out_valid = (st_q.count != CNT_ZERO);
  assign out_data  = st_q.mem[st_q.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ****************************************
  // Next state
  // ****************************************
  // Pointer wrap and count update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr_ptr] = in_data;
      st_d.wr_ptr = (st_q.wr_ptr == PTR_LAST) ? '0 : st_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_d.rd_ptr = (st_q.rd_ptr == PTR_LAST) ? '0 : st_q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_d.count = st_q.count + 1'b1;
    end else if (pop && !push) begin
      st_d.count = st_q.count - 1'b1;
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// file: rtl/rfb_top.sv
// Thirteen-bit registered buffer with two output copies per bit
// Contract
// - A thirteen-bit register stage is presented on twenty-six outputs.
// - Each registered bit drives an A copy and a B copy that always match.
// - Data is sampled when the true clock rises while the complementary clock falls and capture_ready is high, and both copies follow it once drain_ready is high.
// - While reset is low every register is cleared, both copy outputs and receiver_enable are low, and capture_ready is high.
// - While reset is low the input receivers are off and floating inputs have no effect.
`timescale 1ns/1ps
module rfb_top
  import rfb_pkg::*;
(
  input  wire logic                 clk,                  // System clock, 200 MHz
  input  wire logic                 rst_n,                // Synchronous reset, active low
  input  wire logic                 clk_true_in,          // True half of the differential clock pin
  input  wire logic                 clk_comp_in,          // Complementary half of the clock pin
  input  wire logic [RFB_WIDTH-1:0] data_in,              // Data pins
  input  wire logic                 drain_ready,          // Outputs may advance
  output logic                      capture_ready,        // Buffer can take a capture
  output logic                      receiver_enable,      // Input receivers active
  output logic      [RFB_WIDTH-1:0] first_copy_outputs,   // A copy of the register stage
  output logic      [RFB_WIDTH-1:0] second_copy_outputs   // B copy of the register stage
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    rfb_pins_t            sync1;   // First synchroniser stage
    rfb_pins_t            sync2;   // Second synchroniser stage
    rfb_pins_t            prev;    // Previous settled sample
    logic                 rx_en;   // Receivers on
    rfb_outs_t            outs;    // Output register stage
  } rfb_state_t;

  rfb_state_t           st_q;
  rfb_state_t           st_d;
  rfb_pins_t            pins_in;
  rfb_pins_t            pins_seen;
  logic                 cap_valid;
  logic                 cap_ready;
  logic                 buf_valid;
  logic [RFB_WIDTH-1:0] buf_data;
  logic                 buf_take;

  // ****************************************
  // Receivers
  // ****************************************
  // Raw pins feed only the first synchroniser stage, no gating ahead of it
  assign pins_in = '{clk_true: clk_true_in, clk_comp: clk_comp_in, data: data_in};

  // Synchronised view is blanked while the receivers are off
  always_comb begin
    pins_seen = st_q.sync2;
    if (!st_q.rx_en) begin
      pins_seen = '{clk_true: RFB_PIN_RST, clk_comp: RFB_PIN_RST, data: RFB_DATA_RST};
    end
  end

  // ****************************************
  // Capture and drain
  // ****************************************
  // One capture per clock-pair crossing
  assign cap_valid = st_q.rx_en && rfb_crossing(st_q.prev, pins_seen);
  assign buf_take  = buf_valid && drain_ready;
  assign capture_ready = cap_ready;

  rfb_fifo #(
    .WIDTH (RFB_WIDTH),
    .DEPTH (RFB_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (cap_valid),
    .in_ready  (cap_ready),
    .in_data   (pins_seen.data),
    .out_valid (buf_valid),
    .out_ready (drain_ready),
    .out_data  (buf_data)
  );

  // ****************************************
  // Next state
  // ****************************************
  // Synchronise pins, track last sample, load both copies
  always_comb begin
    st_d       = st_q;
    st_d.rx_en = 1'b1;
    st_d.sync1 = pins_in;
    st_d.sync2 = st_q.sync1;
    st_d.prev  = pins_seen;
    // Without a drained word the outputs hold
    if (buf_take) begin
      st_d.outs.copy_a = buf_data;
      st_d.outs.copy_b = buf_data;
    end
  end

  // Register the state; reset clears everything and disables receivers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q.sync1 <= '{clk_true: RFB_PIN_RST, clk_comp: RFB_PIN_RST, data: RFB_DATA_RST};
      st_q.sync2 <= '{clk_true: RFB_PIN_RST, clk_comp: RFB_PIN_RST, data: RFB_DATA_RST};
      st_q.prev  <= '{clk_true: RFB_PIN_RST, clk_comp: RFB_PIN_RST, data: RFB_DATA_RST};
      st_q.rx_en <= 1'b0;
      st_q.outs  <= '{copy_a: RFB_DATA_RST, copy_b: RFB_DATA_RST};
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Both copies straight from flip-flops
  assign first_copy_outputs  = st_q.outs.copy_a;
  assign second_copy_outputs = st_q.outs.copy_b;
  assign receiver_enable     = st_q.rx_en;

endmodule

// file: verif/rfb_checker.sv
// Port checker for the registered fanout buffer
`timescale 1ns/1ps
module rfb_checker
  import rfb_pkg::*;
(
  input wire logic                 clk,                 // System clock
  input wire logic                 rst_n,               // Reset, active low
  input wire logic                 drain_ready,         // Outputs may advance
  input wire logic                 receiver_enable,     // Receivers on
  input wire logic [RFB_WIDTH-1:0] first_copy_outputs,  // A copy
  input wire logic [RFB_WIDTH-1:0] second_copy_outputs  // B copy
);
  // Reset, copy and stall relations
  copies_match_a: assert property (@(posedge clk) disable iff (!rst_n) first_copy_outputs == second_copy_outputs)
    else $error("copies differ");
  reset_clears_a: assert property (@(posedge clk) !rst_n |=> first_copy_outputs == 13'h0000)
    else $error("outputs not low in reset");
  release_low_a: assert property (@(posedge clk) disable iff (!rst_n) !$past(rst_n) |-> first_copy_outputs == 13'h0000)
    else $error("outputs moved on release");
  receivers_off_a: assert property (@(posedge clk) !rst_n |=> !receiver_enable)
    else $error("receivers on in reset");
  receivers_on_a: assert property (@(posedge clk) disable iff (!rst_n) $past(rst_n) |-> receiver_enable)
    else $error("receivers off after reset");
  hold_stall_a: assert property (@(posedge clk) disable iff (!rst_n) !drain_ready |=> $stable(first_copy_outputs))
    else $error("outputs moved while stalled");
  change_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $changed(first_copy_outputs) |-> $past(drain_ready))
    else $error("outputs changed without a take");
endmodule
bind rfb_top rfb_checker u_chk (.clk, .rst_n, .drain_ready, .receiver_enable, .first_copy_outputs, .second_copy_outputs);

// file: verif/rfb_ctrl_model.sv
// Controller model driving the clock pair and data pins
`timescale 1ns/1ps
module rfb_ctrl_model
  import rfb_pkg::*;
(
  input  wire logic                 clk,       // System clock
  output logic                      clk_true,  // True clock pin
  output logic                      clk_comp,  // Complementary clock pin
  output logic      [RFB_WIDTH-1:0] data       // Data pins
);
  // Pins float until woken
  initial float_pins();
  // Undriven pins, legal only while reset is low
  task automatic float_pins();
    clk_true = 1'bx;
    clk_comp = 1'bx;
    data     = 'x;
  endtask
  // Quiet pair after reset
  task automatic idle();
    clk_true = 1'b0;
    clk_comp = 1'b1;
    data     = 13'h0000;
  endtask
  // One crossing carrying w, three cycles per phase
  task automatic send(input logic [RFB_WIDTH-1:0] w);
    data = w;
    repeat (3) @(negedge clk);
    clk_true = 1'b1;
    clk_comp = 1'b0;
    repeat (3) @(negedge clk);
    clk_true = 1'b0;
    clk_comp = 1'b1;
    data     = ~w;  // Hold over, pins move
    repeat (3) @(negedge clk);
  endtask
endmodule

// file: verif/rfb_top_tb_top.sv
// Self-checking bench for the registered fanout buffer
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module rfb_top_tb_top;
  import rfb_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 drain_ready = 1'b1;
  logic                 ct, cc, cap_rdy, rx_en;
  logic [RFB_WIDTH-1:0] d, qa, qb, w, held;
  logic [RFB_WIDTH-1:0] q[$];
  int                   fail_count = 0;
  int                   checks_done = 0;
  int                   cyc = 0;
  // 200 MHz clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  rfb_ctrl_model m (.clk(clk), .clk_true(ct), .clk_comp(cc), .data(d));
  rfb_top dut (.clk(clk), .rst_n(rst_n), .clk_true_in(ct), .clk_comp_in(cc), .data_in(d),
    .drain_ready(drain_ready), .capture_ready(cap_rdy), .receiver_enable(rx_en),
    .first_copy_outputs(qa), .second_copy_outputs(qb));
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Expected output copy: the captured word with reset high, low level in reset
  function automatic logic [RFB_WIDTH-1:0] expect_out(input logic [RFB_WIDTH-1:0] word, input logic rst_hi);
    expect_out = rst_hi ? word : RFB_DATA_RST;
  endfunction
  // Main sequence
  initial begin
    void'($urandom(19996));
    repeat (10) @(negedge clk);
    `CHK(qa, 13'h0000)
    `CHK(rx_en, 1'b0)
    rst_n = 1'b1;
    m.idle();
    repeat (3) @(negedge clk);
    for (int i = 0; i < 20; i++) begin
      w = (i == 0) ? 13'h1FFF : (i == 1) ? 13'h0000 : RFB_WIDTH'($urandom);
      m.send(w);
      `CHK(qa, w)
      `CHK(qb, w)
    end
    held = w;
    drain_ready = 1'b0;
    for (int i = 0; i < 17; i++) begin
      w = RFB_WIDTH'($urandom);
      if (i < 16) q.push_back(w);
      m.send(w);
    end
    `CHK(cap_rdy, 1'b0)
    `CHK(qa, held)
    drain_ready = 1'b1;
    for (int j = 0; j < 16; j++) begin
      @(negedge clk);
      `CHK(qa, q[j])
    end
    repeat (3) @(negedge clk);
    `CHK(qa, q[15])
    `CHK(cap_rdy, 1'b1)
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(qb, 13'h0000)
    // Crossing and floating pins in reset never reach the outputs
    w = RFB_WIDTH'($urandom);
    m.send(w);
    `CHK(qa, expect_out(w, rst_n))
    `CHK(rx_en, 1'b0)
    m.float_pins();
    repeat (3) @(negedge clk);
    `CHK(qb, expect_out(w, rst_n))
    `CHK(cap_rdy, 1'b1)
    // Second release, then one word must pass again
    m.idle();
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    w = RFB_WIDTH'($urandom);
    m.send(w);
    `CHK(qa, expect_out(w, rst_n))
    `CHK(qb, expect_out(w, rst_n))
    end_of_test();
  end
endmodule
